// *** pkg/ser_params.svh ***
// status event reporting: offsets, field positions, reset values
`ifndef SER_PARAMS_SVH
`define SER_PARAMS_SVH
`define SER_W          16
`define SER_NCH        2
`define SER_NTOP       2
`define SER_NCHGRP     3
`define SER_NGRP       8
`define SER_IDXW       3
`define SER_CHW        1
`define SER_APPW       4
`define SER_TYPE_INFO  4'h2
`define SER_TYPE_LAST  4'h4
`define SER_REG_COND   3'h0
`define SER_REG_PTR    3'h1
`define SER_REG_NTR    3'h2
`define SER_REG_EVENT  3'h3
`define SER_REG_ENABLE 3'h4
`define SER_CTRL_BIT   12
`define SER_ACTIVE_REG 3'h0
`define SER_PRESET_REG 3'h1
`define SER_ISTAT_REG  3'h4
`define SER_ICLR_REG   3'h5
`define SER_IEN_REG    3'h6
`define SER_PTR_RST    16'hffff
`define SER_NTR_RST    16'h0000
`define SER_EN_RST     16'h0000
`define SER_RESP_OKAY  2'h0
`define SER_RESP_SLV   2'h2
`endif

// *** pkg/ser_pkg.sv ***
// status event reporting: shared types
`include "ser_params.svh"
package ser_pkg;
	typedef logic [`SER_W-1:0] ser_word_t;
	typedef logic [`SER_NGRP-1:0][`SER_W-1:0] ser_cond_t;
	typedef logic [`SER_NGRP-1:0] ser_grp_t;
	// error notice from one channel's application
	typedef struct packed {
		logic                 valid;
		logic [`SER_CHW-1:0]  ch;
		logic [`SER_APPW-1:0] app;
	} ser_err_s;
	// decoded register address
	typedef struct packed {
		logic                 ok;
		logic                 ctrl;
		logic [`SER_IDXW-1:0] idx;
		logic [2:0]           sel;
	} ser_dec_s;
endpackage : ser_pkg

// *** design/ser_top.sv ***
// status event reporting block with an AXI4-Lite register slave
// Function
// - event read returns bits and clears them
// - enabled event raises the group summary bit
// - mask and filters hold full 16-bit values
// - enabled falling condition sets event bit
// - enabled rising condition sets event bit
// - no channel selection means active channel
// - channel error sets application bit in group_a
// - condition read leaves the condition untouched
// - preset: filters ones/zeros, top masks cleared
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "ser_params.svh"
module ser_top (
	input  wire logic              clk_sys_i,     // system clock
	input  wire logic              rst_b_i,       // async reset, low
	input  wire ser_pkg::ser_cond_t cond_i,       // condition bits per group
	input  wire ser_pkg::ser_err_s err_i,         // channel error notice
	output logic [`SER_NGRP-1:0]   summary_o,     // group summary bits
	output logic                   irq_o,         // level interrupt
	input  wire logic [15:0]       s_axi_awaddr,  // write address
	input  wire logic              s_axi_awvalid, // write address valid
	output logic                   s_axi_awready, // write address ready
	input  wire logic [31:0]       s_axi_wdata,   // write data
	input  wire logic [3:0]        s_axi_wstrb,   // write strobes
	input  wire logic              s_axi_wvalid,  // write data valid
	output logic                   s_axi_wready,  // write data ready
	output logic [1:0]             s_axi_bresp,   // write response
	output logic                   s_axi_bvalid,  // write response valid
	input  wire logic              s_axi_bready,  // write response ready
	input  wire logic [15:0]       s_axi_araddr,  // read address
	input  wire logic              s_axi_arvalid, // read address valid
	output logic                   s_axi_arready, // read address ready
	output logic [31:0]            s_axi_rdata,   // read data
	output logic [1:0]             s_axi_rresp,   // read response
	output logic                   s_axi_rvalid,  // read data valid
	input  wire logic              s_axi_rready   // read data ready
);
	import ser_pkg::*;
	ser_word_t             ptr_reg   [`SER_NGRP];
	ser_word_t             ntr_reg   [`SER_NGRP];
	ser_word_t             en_reg    [`SER_NGRP];
	ser_word_t             ev_reg    [`SER_NGRP];
	ser_word_t             prev_reg  [`SER_NGRP];
	ser_word_t             rise_v    [`SER_NGRP];
	ser_word_t             fall_v    [`SER_NGRP];
	ser_word_t             set_v     [`SER_NGRP];
	ser_grp_t              rclr;
	ser_grp_t              summ_reg;
	ser_grp_t              summ_prev_reg;
	ser_grp_t              istat_reg;
	ser_grp_t              ien_reg;
	logic [`SER_CHW-1:0]   active_reg;
	logic                  aw_have_reg;
	logic                  w_have_reg;
	logic [15:0]           awaddr_reg;
	logic [31:0]           wdata_reg;
	logic [3:0]            wstrb_reg;
	logic                  wr_go;
	logic                  preset;
	logic                  ar_hs;
	ser_dec_s              wdec;
	ser_dec_s              rdec;
	logic [31:0]           rd_data;

	// address to group: bit 12 ctrl, [11:9] channel (0 = active), [8:5] type, [4:2] reg
	function automatic ser_dec_s decode(input logic [15:0] a, input logic [`SER_CHW-1:0] act);
		ser_dec_s            d;
		logic [3:0]          t;
		logic [2:0]          cs;
		logic [`SER_CHW-1:0] ch;
		d    = '0;
		t    = a[8:5];
		cs   = a[11:9];
		ch   = (cs == 3'h0) ? act : 1'(cs - 3'h1);
		d.sel = a[4:2];
		if (a[15:13] != 3'h0 || a[1:0] != 2'h0) begin
			d.ok = 1'b0;
		end else if (a[`SER_CTRL_BIT]) begin
			d.ctrl = 1'b1;
			d.ok   = (a[11:5] == 7'h00) && (d.sel <= `SER_IEN_REG) && (d.sel != 3'h2)
				&& (d.sel != 3'h3);
		end else if (t < `SER_TYPE_INFO) begin
			d.idx = `SER_IDXW'(t);
			d.ok  = (cs == 3'h0) && (d.sel <= `SER_REG_ENABLE);
		end else if (t <= `SER_TYPE_LAST) begin
			d.idx = `SER_IDXW'(`SER_NTOP + (t - `SER_TYPE_INFO) * `SER_NCH + ch);
			d.ok  = (cs <= 3'(`SER_NCH)) && (d.sel <= `SER_REG_ENABLE);
		end
		return d;
	endfunction : decode

	// byte-lane merge; only the low two lanes carry register bits
	function automatic ser_word_t merge(input ser_word_t old, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge

	assign wdec   = decode(awaddr_reg, active_reg);
	assign rdec   = decode(s_axi_araddr, active_reg);
	assign wr_go  = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign ar_hs  = s_axi_arvalid && s_axi_arready;
	assign preset = wr_go && wdec.ok && wdec.ctrl && (wdec.sel == `SER_PRESET_REG)
		&& wstrb_reg[0] && wdata_reg[0];

	// write address and data taken in either order, one write in flight
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SER_RESP_OKAY;
			awaddr_reg    <= 16'h0000;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg   <= 1'b1;
				s_axi_awready <= 1'b0;
				awaddr_reg    <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg   <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wdec.ok ? `SER_RESP_OKAY : `SER_RESP_SLV;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read data mux; condition is read live from the inputs
	always_comb begin
		rd_data = 32'h0000_0000;
		if (rdec.ctrl) begin
			case (rdec.sel)
				`SER_ACTIVE_REG: rd_data = 32'(active_reg);
				`SER_ISTAT_REG:  rd_data = 32'(istat_reg);
				`SER_IEN_REG:    rd_data = 32'(ien_reg);
				default:         rd_data = 32'h0000_0000;
			endcase
		end else begin
			case (rdec.sel)
				`SER_REG_COND:   rd_data = 32'(cond_i[rdec.idx]);
				`SER_REG_PTR:    rd_data = 32'(ptr_reg[rdec.idx]);
				`SER_REG_NTR:    rd_data = 32'(ntr_reg[rdec.idx]);
				`SER_REG_EVENT:  rd_data = 32'(ev_reg[rdec.idx]);
				`SER_REG_ENABLE: rd_data = 32'(en_reg[rdec.idx]);
				default:         rd_data = 32'h0000_0000;
			endcase
		end
	end

	// read channel: one read in flight, data one cycle after address
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SER_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdec.ok ? rd_data : 32'h0000_0000;
			s_axi_rresp   <= rdec.ok ? `SER_RESP_OKAY : `SER_RESP_SLV;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// control registers: active channel, interrupt enable
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			active_reg <= '0;
			ien_reg    <= '0;
		end else if (wr_go && wdec.ok && wdec.ctrl && wstrb_reg[0]) begin
			if (wdec.sel == `SER_ACTIVE_REG) begin
				active_reg <= wdata_reg[`SER_CHW-1:0];
			end
			if (wdec.sel == `SER_IEN_REG) begin
				ien_reg <= wdata_reg[`SER_NGRP-1:0];
			end
		end
	end

	// per-group transition filters, event latch, mask
	genvar g;
	generate
		for (g = 0; g < `SER_NGRP; g++) begin : gen_grp
			logic wsel;
			ser_word_t err_v;
			assign wsel      = wr_go && wdec.ok && !wdec.ctrl && (wdec.idx == g);
			assign rclr[g]   = ar_hs && rdec.ok && !rdec.ctrl && (rdec.idx == g)
				&& (rdec.sel == `SER_REG_EVENT);
			assign rise_v[g] = cond_i[g] & ~prev_reg[g] & ptr_reg[g];
			assign fall_v[g] = ~cond_i[g] & prev_reg[g] & ntr_reg[g];
			assign err_v     = (err_i.valid && (g == `SER_NTOP + err_i.ch))
				? (`SER_W'(1) << err_i.app) : '0;
			assign set_v[g]  = rise_v[g] | fall_v[g] | err_v;

			// full 16-bit values stored, lanes merged
			always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					ptr_reg[g] <= `SER_PTR_RST;
					ntr_reg[g] <= `SER_NTR_RST;
					en_reg[g]  <= `SER_EN_RST;
				end else if (preset) begin
					ptr_reg[g] <= `SER_PTR_RST;
					ntr_reg[g] <= `SER_NTR_RST;
					if (g < `SER_NTOP) begin
						en_reg[g] <= `SER_EN_RST;
					end
				end else if (wsel) begin
					if (wdec.sel == `SER_REG_PTR) begin
						ptr_reg[g] <= merge(ptr_reg[g], wdata_reg, wstrb_reg);
					end
					if (wdec.sel == `SER_REG_NTR) begin
						ntr_reg[g] <= merge(ntr_reg[g], wdata_reg, wstrb_reg);
					end
					if (wdec.sel == `SER_REG_ENABLE) begin
						en_reg[g] <= merge(en_reg[g], wdata_reg, wstrb_reg);
					end
				end
			end

			// set wins over the read clear so no edge is lost
			always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					ev_reg[g]   <= '0;
					prev_reg[g] <= '0;
				end else begin
					prev_reg[g] <= cond_i[g];
					ev_reg[g]   <= (rclr[g] ? '0 : ev_reg[g]) | set_v[g];
				end
			end

			property p_rd_clear;
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				rclr[g] |=> (ev_reg[g] == $past(set_v[g]));
			endproperty
			a_rd_clear: assert property (p_rd_clear) else $error("event read did not clear");
			property p_fall;
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				(fall_v[g] != '0) |=> ((ev_reg[g] & $past(fall_v[g])) == $past(fall_v[g]));
			endproperty
			a_fall: assert property (p_fall) else $error("falling edge not latched");
			property p_rise;
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				(rise_v[g] != '0) |=> ((ev_reg[g] & $past(rise_v[g])) == $past(rise_v[g]));
			endproperty
			a_rise: assert property (p_rise) else $error("rising edge not latched");
			property p_summary;
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				((ev_reg[g] & en_reg[g]) != '0) && !summ_reg[g] |=> summ_reg[g] ##1 summary_o[g];
			endproperty
			a_summary: assert property (p_summary) else $error("summary bit did not rise");
		end
	endgenerate
	// summary, sticky rising-summary status, interrupt level
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			summ_reg      <= '0;
			summ_prev_reg <= '0;
			summary_o     <= '0;
			istat_reg     <= '0;
			irq_o         <= 1'b0;
		end else begin
			for (int i = 0; i < `SER_NGRP; i++) begin
				summ_reg[i] <= |(ev_reg[i] & en_reg[i]);
			end
			summ_prev_reg <= summ_reg;
			summary_o     <= summ_reg;
			// set wins over the write-one clear
			istat_reg     <= (istat_reg & ~((wr_go && wdec.ok && wdec.ctrl
				&& wdec.sel == `SER_ICLR_REG && wstrb_reg[0]) ? wdata_reg[`SER_NGRP-1:0] : '0))
				| (summ_reg & ~summ_prev_reg);
			irq_o         <= |(istat_reg & ien_reg);
		end
	end
	property p_mask_full;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		wr_go && wdec.ok && !wdec.ctrl && wdec.sel == `SER_REG_ENABLE && wstrb_reg[1:0] == 2'h3
		&& !preset |=> en_reg[$past(wdec.idx)] == $past(wdata_reg[15:0]);
	endproperty
	a_mask_full: assert property (p_mask_full) else $error("mask not stored in full");
	property p_active;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		ar_hs && rdec.ok && !rdec.ctrl && s_axi_araddr[11:9] == 3'h0
		&& s_axi_araddr[8:5] == `SER_TYPE_INFO && rdec.sel == `SER_REG_PTR
		|=> s_axi_rdata[15:0] == $past(ptr_reg[`SER_NTOP + active_reg]);
	endproperty
	a_active: assert property (p_active) else $error("unselected read missed channel");
	property p_err_info;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		err_i.valid |=> ev_reg[`SER_NTOP + $past(err_i.ch)][$past(err_i.app)];
	endproperty
	a_err_info: assert property (p_err_info) else $error("error notice not latched");
	property p_cond_rd;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		ar_hs && rdec.ok && !rdec.ctrl && rdec.sel == `SER_REG_COND
		|=> s_axi_rdata == 32'($past(cond_i[rdec.idx])) && s_axi_rvalid;
	endproperty
	a_cond_rd: assert property (p_cond_rd) else $error("condition read wrong");
	property p_preset;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		preset |=> ptr_reg[0] == `SER_PTR_RST && ntr_reg[`SER_NGRP-1] == `SER_NTR_RST
		&& en_reg[0] == `SER_EN_RST && en_reg[1] == `SER_EN_RST;
	endproperty
	a_preset: assert property (p_preset) else $error("preset values wrong");
	property p_irq;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		irq_o == $past(|(istat_reg & ien_reg));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");
	property p_c_rd_event;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		rclr[2] && ev_reg[2] != '0;
	endproperty
	c_rd_event: cover property (p_c_rd_event);
	property p_c_irq;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		$rose(irq_o);
	endproperty
	c_irq: cover property (p_c_irq);
	property p_c_preset;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		preset;
	endproperty
	c_preset: cover property (p_c_preset);
endmodule : ser_top

// *** bench/ser_host_model.sv ***
// host model: AXI4-Lite master issuing status queries and settings
`timescale 1ns/100ps
module ser_host_model (
	input  wire logic        clk_sys_i,     // system clock
	output logic [15:0]      s_axi_awaddr,  // write address
	output logic             s_axi_awvalid, // write address valid
	input  wire logic        s_axi_awready, // write address ready
	output logic [31:0]      s_axi_wdata,   // write data
	output logic [3:0]       s_axi_wstrb,   // write strobes
	output logic             s_axi_wvalid,  // write data valid
	input  wire logic        s_axi_wready,  // write data ready
	input  wire logic [1:0]  s_axi_bresp,   // write response
	input  wire logic        s_axi_bvalid,  // write response valid
	output logic             s_axi_bready,  // write response ready
	output logic [15:0]      s_axi_araddr,  // read address
	output logic             s_axi_arvalid, // read address valid
	input  wire logic        s_axi_arready, // read address ready
	input  wire logic [31:0] s_axi_rdata,   // read data
	input  wire logic [1:0]  s_axi_rresp,   // read response
	input  wire logic        s_axi_rvalid,  // read data valid
	output logic             s_axi_rready   // read data ready
);
	// idle bus from time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// one write; payload inverted once taken so stale values never look valid
	task wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d[15:0]};
		s_axi_wstrb <= 4'h3;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		forever begin
			@(posedge clk_sys_i);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~s_axi_wdata;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : wr
	// one read; data taken at the edge that samples rvalid
	task rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys_i);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		forever begin
			@(posedge clk_sys_i);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : rd
endmodule : ser_host_model

// *** bench/ser_top_bench.sv ***
// testbench: status event reporting block driven over its register bus
`timescale 1ns/100ps
`include "ser_params.svh"
module ser_top_bench;
	import ser_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rst_b_i   = 1'b0;
	ser_cond_t   cond_i    = '0;
	ser_err_s    err_i     = '0;
	logic [7:0]  summary_o;
	logic        irq_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cyc_cnt = 0;
	// half period of 2 ns gives 250 MHz
	always #2 clk_sys_i = ~clk_sys_i;
	ser_top ser_top_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cond_i(cond_i),
		.err_i(err_i), .summary_o(summary_o), .irq_o(irq_o),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	ser_host_model ser_host_model_inst (.clk_sys_i(clk_sys_i),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	// verdict in one place
	task finish_test;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test
	// hang guard, well above the roughly 140 cycles the run needs
	always @(posedge clk_sys_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			error_cnt++;
			finish_test();
		end
	end
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word
	task chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	// byte address from channel select, group type and register
	function automatic logic [15:0] ad(input int c, input int t, input int g);
		return {4'h0, c[2:0], t[3:0], g[2:0], 2'b00};
	endfunction : ad
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : cyc
	task w(input logic [15:0] a, input logic [31:0] d);
		logic [1:0] r;
		ser_host_model_inst.wr(a, d, r);
		chk_word({30'h0, r}, {30'h0, `SER_RESP_OKAY});
	endtask : w
	task rc(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		ser_host_model_inst.rd(a, d, r);
		chk_word(d, e);
		chk_word({30'h0, r}, {30'h0, er});
	endtask : rc
	// main sequence
	initial begin
		repeat (4) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		rc(ad(1, 2, 1), 32'hffff, `SER_RESP_OKAY);
		rc(ad(2, 4, 2), 32'h0, `SER_RESP_OKAY);
		w(ad(0, 0, 4), 32'hffff);
		rc(ad(0, 0, 4), 32'hffff, `SER_RESP_OKAY);
		// rising edge with the default filters, then read-clear
		cond_i[2][3] <= 1'b1;
		cyc(4);
		rc(ad(1, 2, 0), 32'h0008, `SER_RESP_OKAY);
		rc(ad(1, 2, 0), 32'h0008, `SER_RESP_OKAY);
		rc(ad(1, 2, 3), 32'h0008, `SER_RESP_OKAY);
		rc(ad(1, 2, 3), 32'h0, `SER_RESP_OKAY);
		// only the falling filter armed
		w(ad(1, 3, 1), 32'h0);
		w(ad(1, 3, 2), 32'h0001);
		cond_i[4][0] <= 1'b1;
		cyc(4);
		rc(ad(1, 3, 3), 32'h0, `SER_RESP_OKAY);
		cond_i[4][0] <= 1'b0;
		cyc(4);
		rc(ad(1, 3, 3), 32'h0001, `SER_RESP_OKAY);
		// summary and interrupt: masked first, then enabled, then cleared
		w(ad(1, 4, 4), 32'h0020);
		cond_i[6][5] <= 1'b1;
		cyc(6);
		chk_bit(summary_o[6], 1'b1);
		chk_bit(irq_o, 1'b0);
		w(16'h1018, 32'h0040);
		cyc(2);
		chk_bit(irq_o, 1'b1);
		rc(ad(1, 4, 3), 32'h0020, `SER_RESP_OKAY);
		cyc(3);
		chk_bit(summary_o[6], 1'b0);
		rc(16'h1010, 32'h0040, `SER_RESP_OKAY);
		w(16'h1014, 32'h0040);
		cyc(2);
		chk_bit(irq_o, 1'b0);
		// no channel selection follows the active channel
		w(16'h1000, 32'h1);
		w(ad(0, 2, 4), 32'h1234);
		w(ad(2, 2, 1), 32'h00ff);
		rc(ad(0, 2, 1), 32'h00ff, `SER_RESP_OKAY);
		rc(ad(2, 2, 4), 32'h1234, `SER_RESP_OKAY);
		rc(ad(1, 2, 4), 32'h0, `SER_RESP_OKAY);
		// one-cycle error notice from channel 1
		err_i <= '{1'b1, 1'b1, 4'h5};
		@(posedge clk_sys_i);
		err_i.valid <= 1'b0;
		cyc(3);
		rc(ad(2, 2, 3), 32'h0020, `SER_RESP_OKAY);
		rc(ad(1, 2, 3), 32'h0, `SER_RESP_OKAY);
		// preset restores filters and top masks, keeps the others
		w(16'h1004, 32'h1);
		rc(ad(1, 3, 1), 32'hffff, `SER_RESP_OKAY);
		rc(ad(1, 3, 2), 32'h0, `SER_RESP_OKAY);
		rc(ad(0, 0, 4), 32'h0, `SER_RESP_OKAY);
		rc(ad(1, 4, 4), 32'h0020, `SER_RESP_OKAY);
		// refused places answer with an error and zero data
		rc(ad(0, 7, 0), 32'h0, `SER_RESP_SLV);
		rc(ad(1, 0, 4), 32'h0, `SER_RESP_SLV);
		finish_test();
	end
endmodule : ser_top_bench
